/* File: wdcfg_params.svh */
// constants for the watchdog with write-once option register
`ifndef WDCFG_PARAMS_SVH
`define WDCFG_PARAMS_SVH
// register indices, byte address is four times the index
`define WDCFG_IDX_OPTION 16'h001F
`define WDCFG_IDX_SERVICE 16'hFFFF
`define WDCFG_IDX_STATUS 16'h0020
// option register field positions
`define WDCFG_BIT_EDGE 7
`define WDCFG_BIT_BOTPOL 6
`define WDCFG_BIT_TOPPOL 5
`define WDCFG_BIT_PAIR 4
`define WDCFG_BIT_SUPRST 3
`define WDCFG_BIT_SUPPWR 2
`define WDCFG_BIT_STOP_UNUSED 1
`define WDCFG_BIT_WDDIS 0
// status register field positions
`define WDCFG_ST_WD 0
`define WDCFG_ST_SUP 1
// reset values
`define WDCFG_OPTION_RST 8'h00
// timing counts in oscillator cycles
`define WDCFG_TIMEOUT_CYC (2**18 - 2**4)
`define WDCFG_PIN_LOW_CYC 32
`define WDCFG_POR_CYC 4096
`define WDCFG_SUP_FILT_CYC 9
`endif

/* File: wdcfg_pkg.sv */
// types shared by the watchdog block
package wdcfg_pkg;
    // bus transfer kind
    typedef enum logic [1:0] {WDCFG_IDLE, WDCFG_READ, WDCFG_WRITE} wdcfg_op_t;
    // decoded register target
    typedef enum logic [1:0] {WDCFG_R_NONE, WDCFG_R_OPT, WDCFG_R_SVC, WDCFG_R_STAT} wdcfg_reg_t;
endpackage : wdcfg_pkg

/* File: wdcfg_top.sv */
// watchdog timer with write-once option register, wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "wdcfg_params.svh"
module wdcfg_top
    import wdcfg_pkg::*;
#(
    parameter int PRE_W = 13,                   // prescaler width
    parameter int WD_W = 6                      // watchdog counter width
) (
    input wire logic i_ref_clk,                 // oscillator clock, 250 MHz
    input wire logic i_nrst,                    // async power-on reset, low
    input wire logic i_wb_cyc,                  // wishbone cycle
    input wire logic i_wb_stb,                  // wishbone strobe
    input wire logic i_wb_we,                   // wishbone write enable
    input wire logic [17:0] i_wb_adr,           // wishbone byte address
    input wire logic [3:0] i_wb_sel,            // wishbone byte selects
    input wire logic [31:0] i_wb_dat,           // wishbone write data
    output logic o_wb_ack,                      // wishbone acknowledge
    output logic [31:0] o_wb_dat,               // wishbone read data
    input wire logic [7:0] i_reset_vector_lo,   // low byte of reset vector
    input wire logic i_internal_reset,          // other internal reset source
    input wire logic i_vector_fetch,            // reset vector fetch pulse
    input wire logic i_monitor_mode,            // monitor mode active
    input wire logic i_high_test_voltage,       // high voltage on irq or reset pin
    input wire logic i_wait_mode,               // wait mode active
    input wire logic i_stop_mode,               // stop mode active
    input wire logic i_low_supply,              // low-voltage supervisor trip
    output logic o_reset_pin_drive_n,           // reset pin pull, low active
    output logic o_supervisor_reset,            // supervisor reset request
    output logic o_supervisor_power_enable,     // supervisor power enable
    output logic o_edge_align,                  // 1 edge, 0 center aligned
    output logic o_bottom_polarity,             // bottom side negative
    output logic o_top_polarity,                // top side negative
    output logic o_pairing_select               // 1 six independent outputs
);

    // last values of the internal timers, counted from zero
    // the prescaler and watchdog together act as one long counter
    localparam int CNT_W = PRE_W + WD_W;        // combined timeout width
    localparam logic [CNT_W-1:0] TOP_CNT = CNT_W'(`WDCFG_TIMEOUT_CYC - 1);
    localparam logic [12:0] POR_LAST = 13'(`WDCFG_POR_CYC - 1);
    localparam logic [5:0] PIN_LAST = 6'(`WDCFG_PIN_LOW_CYC - 1);
    localparam logic [3:0] SUP_LAST = 4'(`WDCFG_SUP_FILT_CYC - 1);

    // refuse sizes the timeout cannot fit in
    // the service clear needs the low four prescaler bits
    // the check asks for at least nineteen combined bits; the timeout count fits in eighteen
    if (PRE_W < 5 || CNT_W < 19 || CNT_W > 24) begin : g_chk
        $error("wdcfg_top: prescaler and watchdog widths cannot reach the timeout");
    end

    // map a byte address to a register target
    // only word-aligned addresses hit a register, the rest read zero
    function automatic wdcfg_reg_t f_decode(input logic [17:0] adr);
        wdcfg_reg_t r;
        r = WDCFG_R_NONE;
        if (adr[1:0] == 2'h0) begin
            // the service index is shared with the vector byte on reads
            case (adr[17:2])
                `WDCFG_IDX_OPTION: r = WDCFG_R_OPT;
                `WDCFG_IDX_SERVICE: r = WDCFG_R_SVC;
                `WDCFG_IDX_STATUS: r = WDCFG_R_STAT;
                default: r = WDCFG_R_NONE;
            endcase
        end
        return r;
    endfunction : f_decode

    // true when this cycle takes a write to the given register
    function automatic logic f_wr_hit(input wdcfg_op_t o, input wdcfg_reg_t t,
                                      input wdcfg_reg_t want);
        return (o == WDCFG_WRITE) && (t == want);
    endfunction : f_wr_hit

    // register state
    // all timers reset to zero; counts start on the first edge after reset
    logic [7:0] option_q;                       // stored option bits
    logic written_q;                            // option write used up
    logic [1:0] status_q;                       // reset cause flags
    logic [PRE_W-1:0] pre_q;                    // system prescaler
    logic [WD_W-1:0] wd_q;                      // watchdog counter
    logic [12:0] por_q;                         // power-up delay count
    logic por_done_q;                           // power-up clear done
    logic [5:0] pin_q;                          // reset pin low count
    logic pin_busy_q;                           // reset pin pulse running
    logic [3:0] sup_q;                          // low supply persistence
    logic sup_rst_q;                            // supervisor reset held
    logic ack_q;                                // bus ack
    logic [31:0] rdat_q;                        // bus read data

    // decoded bus request
    // a request is taken only while ack is low
    wdcfg_op_t op;                              // transfer kind this cycle
    wdcfg_reg_t tgt;                            // addressed register
    always_comb begin
        tgt = f_decode(i_wb_adr);
        if (i_wb_cyc && i_wb_stb && !ack_q) begin
            op = i_wb_we ? WDCFG_WRITE : WDCFG_READ;
        end else begin
            op = WDCFG_IDLE;
        end
    end

    // service write, any data value; the data byte is never looked at
    logic svc_wr;                               // watchdog service strobe
    assign svc_wr = f_wr_hit(op, tgt, WDCFG_R_SVC);

    // option write, honoured only while the write-once latch is open
    logic opt_wr;                               // option write strobe
    assign opt_wr = f_wr_hit(op, tgt, WDCFG_R_OPT);

    // status write, a one in the low byte clears that cause flag
    logic stat_wr;                              // status write strobe
    assign stat_wr = f_wr_hit(op, tgt, WDCFG_R_STAT);

    // watchdog runs unless disabled, in monitor test or in stop
    // the prescaler keeps running while the watchdog is disabled or in monitor test; stop holds it at zero
    logic wd_run;                               // watchdog clocked this cycle
    assign wd_run = !option_q[`WDCFG_BIT_WDDIS]
        && !(i_monitor_mode && i_high_test_voltage)
        && !i_stop_mode;

    // timeout when the combined count reaches the last cycle
    // a held watchdog never times out, whatever the count
    logic timeout;                              // overflow this cycle
    assign timeout = wd_run && ({wd_q, pre_q} == TOP_CNT);

    // supervisor active only when powered and reset enabled
    logic sup_armed;                            // supervisor may reset
    assign sup_armed = option_q[`WDCFG_BIT_SUPPWR]
        && option_q[`WDCFG_BIT_SUPRST];

    // supervisor trips once nine low cycles have passed
    logic sup_trip;                             // supervisor reset start
    assign sup_trip = sup_armed && i_low_supply && (sup_q == SUP_LAST);

    // any reset of the chip other than power-on
    // clears the option latch, prescaler and watchdog, not the cause flags
    // a held supervisor reset keeps the option register cleared
    logic chip_rst;                             // internal reset event
    assign chip_rst = timeout || sup_trip || sup_rst_q || i_internal_reset;

    // bus acknowledge, one cycle after request, drops next cycle
    // ack masks the request it answers, so a held strobe is taken every other cycle
    // the master drops the strobe for a cycle after each ack
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (op != WDCFG_IDLE);
        end
    end

    // read data mux, unmapped reads return zero
    // read data stays until the next read is taken
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdat_q <= 32'h0000_0000;
        end else if (op == WDCFG_READ) begin
            case (tgt)
                WDCFG_R_OPT: rdat_q <= {24'h00_0000, option_q};
                WDCFG_R_SVC: rdat_q <= {24'h00_0000, i_reset_vector_lo};
                WDCFG_R_STAT: rdat_q <= {30'h0, status_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // write-once option register, cleared by any reset
    // the latch closes on the first write, even one with sel[0] low
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            option_q <= `WDCFG_OPTION_RST;
            written_q <= 1'b0;
        end else if (chip_rst) begin
            // any internal reset reopens the write-once latch
            option_q <= `WDCFG_OPTION_RST;
            written_q <= 1'b0;
        end else if (opt_wr && !written_q) begin
            // first write after reset, all eight bits kept when sel[0] is set
            if (i_wb_sel[0]) begin
                option_q <= i_wb_dat[7:0];
            end
            written_q <= 1'b1;
        end
        // later writes fall through untouched
    end

    // reset cause flags, write one to clear, set wins
    // a timeout or trip in the clearing cycle keeps its flag set
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == `WDCFG_ST_WD && timeout) begin
                    status_q[i] <= 1'b1;
                end else if (i == `WDCFG_ST_SUP && sup_trip) begin
                    status_q[i] <= 1'b1;
                end else if (stat_wr && i_wb_sel[0] && i_wb_dat[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    // power-up delay before the prescaler clear
    // counts once after power-on, then stops until the next power-on
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            por_q <= 13'h0000;
            por_done_q <= 1'b0;
        end else if (!por_done_q) begin
            por_q <= por_q + 13'h0001;
            por_done_q <= (por_q == POR_LAST);
        end
    end

    // system prescaler, free running on the oscillator clock
    // priority: internal reset or vector fetch, power-up clear, stop,
    // service write, then plain counting
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_q <= '0;
        end else if (chip_rst || i_vector_fetch) begin
            pre_q <= '0;
        end else if (!por_done_q && por_q == POR_LAST) begin
            pre_q <= '0;
        end else if (i_stop_mode) begin
            pre_q <= '0;
        end else if (svc_wr) begin
            // upper bits cleared, low four keep counting
            pre_q <= {{(PRE_W-4){1'b0}}, pre_q[3:0] + 4'h1};
        end else begin
            // wait mode does not stop the count
            pre_q <= pre_q + 1'b1;
        end
    end

    // watchdog counter stepped by the prescaler carry
    // steps in the cycle in which the prescaler wraps
    // stop mode holds the prescaler at zero so no carry arrives
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wd_q <= '0;
        end else if (chip_rst || svc_wr) begin
            wd_q <= '0;
        end else if (wd_run && (&pre_q)) begin
            wd_q <= wd_q + 1'b1;
        end
    end

    // reset pin pulse on watchdog timeout
    // the timeout cycle itself drives the pin, the count covers the rest
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_q <= 6'h00;
            pin_busy_q <= 1'b0;
        end else if (timeout) begin
            pin_q <= 6'h00;
            pin_busy_q <= 1'b1;
        end else if (pin_busy_q) begin
            // stops itself on the last count
            pin_q <= pin_q + 6'h01;
            pin_busy_q <= (pin_q != PIN_LAST);
        end
    end

    // reset pin output, low while the pulse runs
    // 32 cycles low in all: the timeout cycle plus 31 counted cycles
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reset_pin_drive_n <= 1'b1;
        end else begin
            o_reset_pin_drive_n <= !(timeout || (pin_busy_q && pin_q != PIN_LAST));
        end
    end

    // low supply persistence filter
    // a single cycle without the supply flag restarts the count
    // saturates at the last count while the flag stays high
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sup_q <= 4'h0;
        end else if (!sup_armed || !i_low_supply) begin
            sup_q <= 4'h0;
        end else if (sup_q != SUP_LAST) begin
            sup_q <= sup_q + 4'h1;
        end
    end

    // supervisor reset held until the low supply clears
    // the trip forces an internal reset that also disarms the filter
    // cleared only when the supply flag drops
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sup_rst_q <= 1'b0;
        end else if (sup_trip) begin
            sup_rst_q <= 1'b1;
        end else if (!i_low_supply) begin
            sup_rst_q <= 1'b0;
        end
    end

    // option outputs, each from its own flop
    // outputs lag the option register by one cycle
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_edge_align <= 1'b0;
            o_bottom_polarity <= 1'b0;
            o_top_polarity <= 1'b0;
            o_pairing_select <= 1'b0;
            o_supervisor_power_enable <= 1'b0;
        end else begin
            o_edge_align <= option_q[`WDCFG_BIT_EDGE];
            o_bottom_polarity <= option_q[`WDCFG_BIT_BOTPOL];
            o_top_polarity <= option_q[`WDCFG_BIT_TOPPOL];
            o_pairing_select <= option_q[`WDCFG_BIT_PAIR];
            o_supervisor_power_enable <= option_q[`WDCFG_BIT_SUPPWR];
        end
    end

    // supervisor reset request, high from the trip until the supply recovers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_supervisor_reset <= 1'b0;
        end else begin
            o_supervisor_reset <= sup_trip || sup_rst_q;
        end
    end

    // bus outputs; the watchdog has no interrupt output at all
    // ack and read data come straight from their registers
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // wait mode input only documents that the count keeps going
    // nothing in the watchdog path reads it
    logic unused_wait;                          // deliberately unread mode
    assign unused_wait = i_wait_mode;

endmodule : wdcfg_top
`default_nettype wire

/* File: wdcfg_asserts.sv */
// concurrent checks on the ports of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module wdcfg_asserts (
    input wire logic i_ref_clk, // clock
    input wire logic i_nrst, // async reset, low
    input wire logic i_wb_cyc, // bus cycle
    input wire logic i_wb_stb, // bus strobe
    input wire logic i_wb_we, // bus direction
    input wire logic [17:0] i_wb_adr, // byte address
    input wire logic [7:0] i_reset_vector_lo, // vector low byte
    input wire logic i_low_supply, // supervisor trip
    input wire logic o_wb_ack, // bus answer
    input wire logic [31:0] o_wb_dat, // read data
    input wire logic o_reset_pin_drive_n, // reset pin, low active
    input wire logic o_supervisor_reset, // supervisor reset
    input wire logic o_supervisor_power_enable, // option bit 2
    input wire logic o_edge_align, // option bit 7
    input wire logic o_bottom_polarity, // option bit 6
    input wire logic o_top_polarity, // option bit 5
    input wire logic o_pairing_select // option bit 4
);
    logic [3:0] low_cnt_q; // consecutive low-supply cycles, saturating
    logic [5:0] pin_cnt_q; // cycles the reset pin has been low
    logic [4:0] cfg; // option outputs gathered
    assign cfg = {o_edge_align, o_bottom_polarity, o_top_polarity, o_pairing_select,
        o_supervisor_power_enable};
    // filter length seen at the pin
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) low_cnt_q <= 4'h0;
        else if (!i_low_supply) low_cnt_q <= 4'h0;
        else if (low_cnt_q != 4'hF) low_cnt_q <= low_cnt_q + 4'h1;
    end
    // reset pulse length
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) pin_cnt_q <= 6'h00;
        else if (o_reset_pin_drive_n) pin_cnt_q <= 6'h00;
        else pin_cnt_q <= pin_cnt_q + 6'h01;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_take; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
    sequence s_rd; s_take ##0 !i_wb_we; endsequence
    property p_ack_lat; s_take |=> o_wb_ack; endproperty
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    property p_opt_rd; s_rd ##0 (i_wb_adr == 18'h0007C) |=> o_wb_dat[31:8] == 24'h0
        && {o_wb_dat[7:4], o_wb_dat[2]} == cfg; endproperty
    property p_vec_rd; s_rd ##0 (i_wb_adr == 18'h3FFFC)
        |=> o_wb_dat == {24'h0, $past(i_reset_vector_lo)}; endproperty
    property p_unaligned; s_rd ##0 (i_wb_adr[1:0] != 2'h0) |=> o_wb_dat == 32'h0; endproperty
    property p_cfg_cause; !$stable(cfg) |-> $past(o_wb_ack) || cfg == 5'h00; endproperty
    property p_sup_filter; $rose(o_supervisor_reset) |-> low_cnt_q >= 4'h9; endproperty
    property p_sup_hold; !i_low_supply [*2] |=> !o_supervisor_reset; endproperty
    property p_pin_low; $rose(o_reset_pin_drive_n) |-> pin_cnt_q == 6'h20; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_opt_rd: assert property (p_opt_rd) else $error("option read");
    a_vec_rd: assert property (p_vec_rd) else $error("vector read");
    a_unaligned: assert property (p_unaligned) else $error("bad read");
    a_cfg_cause: assert property (p_cfg_cause) else $error("option moved");
    a_sup_filter: assert property (p_sup_filter) else $error("short filter");
    a_sup_hold: assert property (p_sup_hold) else $error("supervisor held");
    a_pin_low: assert property (p_pin_low) else $error("pin pulse");
endmodule : wdcfg_asserts
bind wdcfg_top wdcfg_asserts u_asserts (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_reset_vector_lo(i_reset_vector_lo),
    .i_low_supply(i_low_supply),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat),
    .o_reset_pin_drive_n(o_reset_pin_drive_n),
    .o_supervisor_reset(o_supervisor_reset),
    .o_supervisor_power_enable(o_supervisor_power_enable),
    .o_edge_align(o_edge_align),
    .o_bottom_polarity(o_bottom_polarity),
    .o_top_polarity(o_top_polarity),
    .o_pairing_select(o_pairing_select)
);
`default_nettype wire

/* File: wdcfg_tb.sv */
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wdcfg_pkg::*;
    logic i_ref_clk = 1'b0, i_nrst = 1'b0; // clock and power-on reset
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0; // bus controls
    logic [17:0] i_wb_adr = 18'h0; // byte address
    logic [3:0] i_wb_sel = 4'h0; // byte selects
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q, pins; // bus data, last read, outputs
    logic [7:0] i_reset_vector_lo = 8'h0, v; // vector byte, option byte
    logic i_internal_reset = 1'b0, i_vector_fetch = 1'b0, i_monitor_mode = 1'b0;
    logic i_high_test_voltage = 1'b0, i_wait_mode = 1'b0, i_stop_mode = 1'b0;
    logic i_low_supply = 1'b0, o_wb_ack, o_reset_pin_drive_n, o_supervisor_reset;
    logic o_supervisor_power_enable, o_edge_align, o_bottom_polarity;
    logic o_top_polarity, o_pairing_select;
    int errors = 0, samples_checked = 0;
    localparam logic [17:0] ADR_OPT = 18'h0007C, ADR_SVC = 18'h3FFFC, ADR_ST = 18'h00080;
    assign pins = {27'h0, o_edge_align, o_bottom_polarity, o_top_polarity,
        o_pairing_select, o_supervisor_power_enable};
    wdcfg_top u_dut (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel),
        .i_wb_dat(i_wb_dat),
        .o_wb_ack(o_wb_ack),
        .o_wb_dat(o_wb_dat),
        .i_reset_vector_lo(i_reset_vector_lo),
        .i_internal_reset(i_internal_reset),
        .i_vector_fetch(i_vector_fetch),
        .i_monitor_mode(i_monitor_mode),
        .i_high_test_voltage(i_high_test_voltage),
        .i_wait_mode(i_wait_mode),
        .i_stop_mode(i_stop_mode),
        .i_low_supply(i_low_supply),
        .o_reset_pin_drive_n(o_reset_pin_drive_n),
        .o_supervisor_reset(o_supervisor_reset),
        .o_supervisor_power_enable(o_supervisor_power_enable),
        .o_edge_align(o_edge_align),
        .o_bottom_polarity(o_bottom_polarity),
        .o_top_polarity(o_top_polarity),
        .o_pairing_select(o_pairing_select)
    );
    // 250 MHz clock
    initial forever #2 i_ref_clk = ~i_ref_clk;
    // option outputs expected from a stored byte
    function automatic logic [31:0] exp_pins(input logic [7:0] b);
        return {27'h0, b[7:4], b[2]};
    endfunction : exp_pins
    // supervisor reset expected after n low cycles
    function automatic logic [31:0] sup_exp(input int n);
        return {31'h0, n >= 9};
    endfunction : sup_exp
    task automatic test_done;
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic cycle, waits for ack under a bound
    task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        i_wb_sel <= 4'hF;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 64);
        if (n >= 64) errors++;
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask : wb
    // low supply for n cycles, then released
    task automatic low_run(input int n);
        i_low_supply <= 1'b1;
        repeat (n) @(posedge i_ref_clk);
        i_low_supply <= 1'b0;
        @(posedge i_ref_clk);
        chk("sup_trip", sup_exp(n), {31'h0, o_supervisor_reset});
        repeat (4) @(posedge i_ref_clk);
        chk("sup_release", 32'h0, {31'h0, o_supervisor_reset});
    endtask : low_run
    initial begin
        void'($urandom(32'hF2DF));
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        wb(1'b0, ADR_OPT, 32'h0);
        chk("opt_reset", 32'h0, q);
        chk("pins_reset", 32'h0, pins);
        v = 8'($urandom()) & 8'hFE;
        wb(1'b1, ADR_OPT, {24'h0, v});
        wb(1'b0, ADR_OPT, 32'h0);
        chk("opt_read", {24'h0, v}, q);
        chk("opt_pins", exp_pins(v), pins);
        wb(1'b1, ADR_OPT, {24'h0, ~v});
        wb(1'b0, ADR_OPT, 32'h0);
        chk("opt_once", {24'h0, v}, q);
        for (int i = 0; i < 4; i++) begin
            i_reset_vector_lo <= 8'($urandom());
            wb(1'b0, ADR_SVC, 32'h0);
            chk("vector", {24'h0, i_reset_vector_lo}, q);
        end
        wb(1'b0, 18'h00101, 32'h0);
        chk("unaligned", 32'h0, q);
        // serviced run through wait and stop spans
        for (int i = 0; i < 20; i++) begin
            i_wait_mode <= i[0];
            i_monitor_mode <= i[1];
            i_high_test_voltage <= i[2];
            i_stop_mode <= (i % 5 == 4);
            repeat (2000) @(posedge i_ref_clk);
            i_vector_fetch <= 1'b1;
            @(posedge i_ref_clk);
            i_vector_fetch <= 1'b0;
            wb(1'b1, ADR_SVC, $urandom());
            chk("pin_idle", 32'h1, {31'h0, o_reset_pin_drive_n});
        end
        i_internal_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_internal_reset <= 1'b0;
        wb(1'b0, ADR_OPT, 32'h0);
        chk("opt_int_reset", 32'h0, q);
        wb(1'b1, ADR_OPT, 32'h0000000C);
        low_run(8);
        low_run(12);
        wb(1'b0, ADR_OPT, 32'h0);
        chk("opt_sup_reset", 32'h0, q);
        wb(1'b0, ADR_ST, 32'h0);
        chk("status", 32'h2, q);
        test_done();
    end
    // hang guard, under twice the planned run
    initial begin
        #300000;
        errors++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
